//--- core/ssd_pkg.sv
/*
  shared constants and carrier types for the host-side controller of the
  scsi status, interrupt and dma-start block.
  assumes a 10 MHz pclk and the device's 8-bit register port.
*/
`default_nettype none
package ssd_pkg;
  // apb map of the controller's own registers
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] ARB_OFS = 8'h08;
  localparam logic [7:0] MODE_OFS = 8'h0c;
  // command register fields
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_WRITE_BIT = 16;
  // status register fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_REFUSED_BIT = 1;
  localparam int ST_ARB_BIT = 2;
  localparam int ST_IDOK_BIT = 3;
  localparam int ST_IRQ_BIT = 4;
  localparam int ST_RDATA_LSB = 8;
  // device register offsets
  localparam logic [2:0] DEV_CUR_DATA = 3'h0;
  localparam logic [2:0] DEV_MODE = 3'h2;
  localparam logic [2:0] DEV_SEND = 3'h5;
  localparam logic [2:0] DEV_TRX = 3'h6;
  localparam logic [2:0] DEV_IRX = 3'h7;
  // device mode register bits
  localparam int MODE_DMA_BIT = 1;
  localparam int MODE_ROLE_BIT = 6;
  localparam logic [7:0] MODE_RESET = 8'h00;
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int ARB_DELAY_NS = 2200;
  localparam int STROBE_NS = 200;
  localparam int ARB_CYC = (ARB_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MAX_IDS = 2;

  // device port control pins, all active low except the address
  typedef struct packed {
    logic [2:0] addr;
    logic cs_n;
    logic rd_n;
    logic wr_n;
  } ssd_dev_ctl_t;

  // one queued device access
  typedef struct packed {
    logic write;
    logic [2:0] addr;
    logic [7:0] data;
  } ssd_cmd_t;
endpackage
`default_nettype wire

//--- core/ssd_host_ctrl.sv
/*
  host-side controller: takes apb orders and runs single register accesses
  on the device's 8-bit port, guarding dma triggers and arbitration timing.
  assumes the device's data pins are joined to a shared wire by the bench,
  and that every input is synchronous to pclk.
*/
`timescale 1ns/1ns
`default_nettype none
module ssd_host_ctrl (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // device register port
  output ssd_pkg::ssd_dev_ctl_t dev_ctl,
  output logic [7:0] dev_data_out,
  output logic dev_data_oe_n,
  input wire logic [7:0] dev_data_in,
  input wire logic dev_irq
);
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} ssd_state_t;

  ssd_state_t state;
  ssd_pkg::ssd_cmd_t cmd;
  logic [7:0] mode;
  logic [7:0] rdata;
  logic [4:0] arb_cnt;
  logic [1:0] stb_cnt;
  logic refused;
  logic id_ok;

  // at most the allowed number of ids may be active on the data bus
  function automatic logic ids_ok(input logic [7:0] d);
    return $countones(d) <= ssd_pkg::MAX_IDS;
  endfunction

  // a trigger write is legal only with its mode bits: dma enable for all three, plus target role for trx and initiator role for irx
  function automatic logic guard_ok(input ssd_pkg::ssd_cmd_t c, input logic [7:0] m);
    logic dma;
    logic tgt;
    dma = m[ssd_pkg::MODE_DMA_BIT];
    tgt = m[ssd_pkg::MODE_ROLE_BIT];
    if (!c.write)
      return 1'b1;
    unique case (c.addr)
      ssd_pkg::DEV_SEND: return dma;
      ssd_pkg::DEV_TRX: return dma & tgt;
      ssd_pkg::DEV_IRX: return dma & ~tgt;
      default: return 1'b1;
    endcase
  endfunction

  // apb decode
  logic apb_setup;
  logic apb_wr;
  logic map_hit;
  logic cmd_hit;
  logic arb_hit;
  logic arb_busy;
  logic busy;
  logic accept;
  logic arb_block;
  ssd_pkg::ssd_cmd_t new_cmd;
  assign apb_setup = psel & ~penable;
  assign apb_wr = psel & penable & pwrite;
  assign map_hit = paddr == ssd_pkg::CMD_OFS || paddr == ssd_pkg::STATUS_OFS
                   || paddr == ssd_pkg::ARB_OFS || paddr == ssd_pkg::MODE_OFS;
  assign cmd_hit = apb_wr & (paddr == ssd_pkg::CMD_OFS);
  assign arb_hit = apb_wr & (paddr == ssd_pkg::ARB_OFS);
  assign new_cmd = '{write: pwdata[ssd_pkg::CMD_WRITE_BIT], addr: pwdata[ssd_pkg::CMD_ADDR_LSB +: 3],
                     data: pwdata[7:0]};
  assign arb_busy = arb_cnt != 5'h00;
  assign busy = state != ST_IDLE;
  // the data bus must not be judged until the arbitration delay is over
  assign arb_block = arb_busy & ~new_cmd.write & (new_cmd.addr == ssd_pkg::DEV_CUR_DATA);
  assign accept = cmd_hit & ~busy & ~arb_block & guard_ok(new_cmd, mode);
  assign pready = 1'b1;

  // read mux is sampled in the setup phase so prdata comes from a flop
  logic [31:0] next_prdata;
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      ssd_pkg::CMD_OFS:
      begin
        next_prdata[ssd_pkg::CMD_WRITE_BIT] = cmd.write;
        next_prdata[ssd_pkg::CMD_ADDR_LSB +: 3] = cmd.addr;
        next_prdata[7:0] = cmd.data;
      end
      ssd_pkg::STATUS_OFS:
      begin
        next_prdata[ssd_pkg::ST_BUSY_BIT] = busy;
        next_prdata[ssd_pkg::ST_REFUSED_BIT] = refused;
        next_prdata[ssd_pkg::ST_ARB_BIT] = arb_busy;
        next_prdata[ssd_pkg::ST_IDOK_BIT] = id_ok;
        next_prdata[ssd_pkg::ST_IRQ_BIT] = dev_irq;
        next_prdata[ssd_pkg::ST_RDATA_LSB +: 8] = rdata;
      end
      ssd_pkg::ARB_OFS: next_prdata[4:0] = arb_cnt;
      ssd_pkg::MODE_OFS: next_prdata[7:0] = mode;
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (apb_setup)
    begin
      prdata <= next_prdata;
      pslverr <= ~map_hit;
    end
  end

  // access sequencer: setup, strobe for the pulse width, hold
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_IDLE;
      stb_cnt <= 2'h0;
    end
    else
    begin
      unique case (state)
        ST_IDLE: if (accept) state <= ST_SETUP;
        ST_SETUP:
        begin
          state <= ST_STROBE;
          stb_cnt <= 2'(ssd_pkg::STROBE_CYC);
        end
        ST_STROBE:
        begin
          stb_cnt <= stb_cnt - 2'h1;
          if (stb_cnt == 2'h1) state <= ST_HOLD;
        end
        ST_HOLD: state <= ST_IDLE;
      endcase
    end
  end

  // command latch and refusal flag; each command write sets or clears the flag by its outcome
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd <= '0;
      refused <= 1'b0;
    end
    else if (cmd_hit)
    begin
      if (accept) cmd <= new_cmd;
      refused <= ~accept;
    end
  end

  // read data is taken on the last strobe cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata <= 8'h00;
    else if (state == ST_STROBE && stb_cnt == 2'h1 && !cmd.write)
      rdata <= dev_data_in;
  end

  // mode shadow follows writes and reads of the device mode register
  logic mode_done;
  assign mode_done = state == ST_HOLD && cmd.addr == ssd_pkg::DEV_MODE;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode <= ssd_pkg::MODE_RESET;
    else if (mode_done)
      mode <= cmd.write ? cmd.data : rdata;
  end

  // id count is judged on every completed read of the live data bus
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      id_ok <= 1'b1;
    else if (state == ST_HOLD && !cmd.write && cmd.addr == ssd_pkg::DEV_CUR_DATA)
      id_ok <= ids_ok(rdata);
  end

  // arbitration wait counter; a software write restarts the full delay
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      arb_cnt <= 5'h00;
    else if (arb_hit)
      arb_cnt <= 5'(ssd_pkg::ARB_CYC);
    else if (arb_busy)
      arb_cnt <= arb_cnt - 5'h01;
  end

  // pin drive; data bus driven only while a write access is under way
  logic strobe;
  assign strobe = state == ST_STROBE;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dev_ctl <= '{addr: 3'h0, cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1};
      dev_data_out <= 8'h00;
      dev_data_oe_n <= 1'b1;
    end
    else
    begin
      dev_ctl.addr <= cmd.addr;
      dev_ctl.cs_n <= ~(state == ST_SETUP || strobe);
      dev_ctl.rd_n <= ~(state == ST_SETUP ? 1'b0 : (strobe && stb_cnt != 2'h1 && !cmd.write));
      dev_ctl.wr_n <= ~(strobe && stb_cnt != 2'h1 && cmd.write);
      dev_data_out <= cmd.data;
      dev_data_oe_n <= ~(cmd.write && (state == ST_SETUP || strobe));
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  localparam int ARB_LAST_A = ssd_pkg::ARB_CYC - 1;

  sequence write_pulse(logic [2:0] a);
    !dev_ctl.wr_n && dev_ctl.addr == a;
  endsequence

  // a refused order leaves the port idle, so nothing reaches the pins
  sequence refused_idle;
    refused && state == ST_IDLE;
  endsequence

  send_guard_a: assert property (write_pulse(ssd_pkg::DEV_SEND) |-> mode[ssd_pkg::MODE_DMA_BIT])
    else $error("send trigger without dma enable");
  trx_guard_a: assert property (write_pulse(ssd_pkg::DEV_TRX)
    |-> mode[ssd_pkg::MODE_DMA_BIT] && mode[ssd_pkg::MODE_ROLE_BIT])
    else $error("target receive trigger with wrong mode");
  irx_guard_a: assert property (write_pulse(ssd_pkg::DEV_IRX) |-> !mode[ssd_pkg::MODE_ROLE_BIT])
    else $error("initiator receive trigger in target role");
  arb_wait_a: assert property ($rose(arb_busy) |-> ##ARB_LAST_A arb_busy ##1 !arb_busy)
    else $error("arbitration wait length wrong");
  arb_read_a: assert property (!dev_ctl.rd_n && dev_ctl.addr == ssd_pkg::DEV_CUR_DATA
    |-> !arb_busy || $past(arb_hit))
    else $error("data bus read during arbitration delay");
  id_check_a: assert property (state == ST_HOLD && !cmd.write && cmd.addr == ssd_pkg::DEV_CUR_DATA
    |=> id_ok == ($countones(rdata) <= 2))
    else $error("id count flag wrong");
  strobe_len_a: assert property (state == ST_SETUP |-> ##1 strobe [*2] ##1 state == ST_HOLD)
    else $error("strobe width wrong");
  refuse_flag_a: assert property (cmd_hit && busy |=> refused && $stable(cmd))
    else $error("busy command not refused");
  send_refuse_a: assert property (cmd_hit && !busy && new_cmd.write
    && new_cmd.addr == ssd_pkg::DEV_SEND && !mode[ssd_pkg::MODE_DMA_BIT] |=> refused_idle)
    else $error("send trigger accepted without dma enable");
  irx_refuse_a: assert property (cmd_hit && !busy && new_cmd.write
    && new_cmd.addr == ssd_pkg::DEV_IRX && mode[ssd_pkg::MODE_ROLE_BIT] |=> refused_idle)
    else $error("initiator receive trigger accepted in target role");
  arb_refuse_a: assert property (cmd_hit && !busy && arb_busy && !new_cmd.write
    && new_cmd.addr == ssd_pkg::DEV_CUR_DATA |=> refused_idle)
    else $error("data bus read accepted during arbitration delay");
  // the data bus is driven only inside the select window, never against the device
  drive_window_a: assert property (!dev_data_oe_n |-> !dev_ctl.cs_n)
    else $error("data driven outside select");
endmodule
`default_nettype wire

//--- tb/ssd_dev_model.sv
/*
  device model: register port of the scsi block, its flags and dma triggers.
  assumes the bench resolves the shared data wire.
*/
`timescale 1ns/1ns
`default_nettype none
module ssd_dev_model (
  // clock and chip reset
  input wire logic pclk,
  input wire logic presetn,
  // register port
  input wire ssd_pkg::ssd_dev_ctl_t ctl,
  input wire logic [7:0] din,
  output wire logic [7:0] dq,
  output var logic irq,
  // bus conditions from the bench
  input wire logic [7:0] cur_data,
  input wire logic lose_busy
);
  logic [7:0] mode, mask, last, n_send, n_trx, n_irx;
  logic busy_err, prev_wr, prev_rd;
  // accesses act once, on the strobe's leading edge
  wire wr_go = !ctl.cs_n && !ctl.wr_n && prev_wr;
  wire rd_go = !ctl.cs_n && !ctl.rd_n && prev_rd;
  wire [7:0] rv = ctl.addr == ssd_pkg::DEV_MODE ? mode :
    ctl.addr == 3'h5 ? {3'h0, irq, 1'b0, busy_err, 2'h0} : cur_data;
  // a released bus toggles, so a stale byte never passes for data
  assign dq = (!ctl.cs_n && !ctl.rd_n) ? rv : ~last;

  // chip reset clears every latch but the strobe history, which it sets high, the interrupt included
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {mode, mask, last, n_send, n_trx, n_irx} <= 48'h0;
      {busy_err, irq} <= 2'h0;
      {prev_wr, prev_rd} <= 2'h3;
    end
    else
    begin
      prev_wr <= ctl.wr_n;
      prev_rd <= ctl.rd_n;
      last <= dq;
      if (wr_go && ctl.addr == 3'h4) mask <= din;
      if (wr_go && ctl.addr == ssd_pkg::DEV_SEND && mode[1]) n_send <= n_send + 8'h1;
      if (wr_go && ctl.addr == ssd_pkg::DEV_TRX && mode[1] && mode[6]) n_trx <= n_trx + 8'h1;
      if (wr_go && ctl.addr == ssd_pkg::DEV_IRX && !mode[6]) n_irx <= n_irx + 8'h1;
      // a busy loss counts only under busy monitoring, and beats a clear in the same cycle
      if (lose_busy && mode[2])
      begin
        busy_err <= 1'b1;
        irq <= 1'b1;
        mode[1] <= 1'b0;
      end
      else
      begin
        if (wr_go && ctl.addr == ssd_pkg::DEV_MODE) mode <= din;
        if (rd_go && ctl.addr == ssd_pkg::DEV_IRX) {busy_err, irq} <= 2'h0;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/scsi_status_irq_dma_start_bench.sv
/*
  self-checking bench for the host controller with a device model behind it.
  assumes the apb slave answers on its own and the model stands at the port.
*/
`timescale 1ns/1ns
`default_nettype none
module scsi_status_irq_dma_start_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] cur_data = 8'h00;
  logic lose_busy = 1'b0;
  logic [31:0] q;
  logic e;
  int num_errors = 0;
  int checks = 0;
  wire pready;
  wire [31:0] prdata;
  wire pslverr;
  ssd_pkg::ssd_dev_ctl_t dev_ctl;
  wire [7:0] dev_data_out;
  wire [7:0] dq;
  wire dev_data_oe_n;
  wire dev_irq;
  // the shared data wire follows whoever is enabled
  wire [7:0] dbus = dev_data_oe_n ? dq : dev_data_out;

  always #50 pclk = ~pclk;

  ssd_host_ctrl u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .dev_ctl(dev_ctl), .dev_data_out(dev_data_out), .dev_data_oe_n(dev_data_oe_n),
    .dev_data_in(dbus), .dev_irq(dev_irq));
  ssd_dev_model u_dev (.pclk(pclk), .presetn(presetn), .ctl(dev_ctl), .din(dbus), .dq(dq),
    .irq(dev_irq), .cur_data(cur_data), .lose_busy(lose_busy));

  task automatic print_verdict;
    if (num_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer; read data and error are taken at the ready edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      num_errors++;
      print_verdict();
    end
  endtask

  // device access by command, then the status once the port is idle
  task automatic dev(input logic wr, input logic [2:0] ofs, input logic [7:0] d);
    int n;
    n = 0;
    apb(1'b1, ssd_pkg::CMD_OFS, {15'h0, wr, 5'h0, ofs, d});
    do
    begin
      apb(1'b0, ssd_pkg::STATUS_OFS, 32'h0);
      n++;
    end
    while (q[0] !== 1'b0 && n < 20);
    apb(1'b0, ssd_pkg::STATUS_OFS, 32'h0);
    if (q[0] !== 1'b0)
    begin
      num_errors++;
      print_verdict();
    end
  endtask

  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ssd_pkg::STATUS_OFS, 32'h0);
    check(q, 32'h8);
    apb(1'b0, 8'h10, 32'h0);
    check({31'h0, e}, 32'h1);
    // dma triggers against the enable and role guards
    dev(1'b1, ssd_pkg::DEV_SEND, 8'h5a);
    check(q & 32'h1f, 32'h0a);
    dev(1'b1, ssd_pkg::DEV_MODE, 8'h02);
    dev(1'b1, ssd_pkg::DEV_SEND, 8'hff);
    check(q & 32'h1f, 32'h08);
    dev(1'b1, ssd_pkg::DEV_TRX, 8'h00);
    check(q & 32'h1f, 32'h0a);
    dev(1'b1, ssd_pkg::DEV_IRX, 8'h00);
    check(q & 32'h1f, 32'h08);
    dev(1'b1, ssd_pkg::DEV_MODE, 8'h42);
    dev(1'b1, ssd_pkg::DEV_TRX, 8'h00);
    check(q & 32'h1f, 32'h08);
    dev(1'b1, ssd_pkg::DEV_IRX, 8'h00);
    check(q & 32'h1f, 32'h0a);
    check({u_dev.n_send, u_dev.n_trx, u_dev.n_irx, u_dev.mode}, 32'h01010142);
    apb(1'b0, ssd_pkg::MODE_OFS, 32'h0);
    check(q, 32'h42);
    dev(1'b1, 3'h4, 8'h81);
    check({24'h0, u_dev.mask}, 32'h81);
    apb(1'b0, ssd_pkg::CMD_OFS, 32'h0);
    check(q, 32'h0001_0481);
    // three ids on the bus fail the count, two pass
    cur_data <= 8'h07;
    dev(1'b0, ssd_pkg::DEV_CUR_DATA, 8'h00);
    check(q & 32'hff1f, 32'h0700);
    cur_data <= 8'h05;
    dev(1'b0, ssd_pkg::DEV_CUR_DATA, 8'h00);
    check(q & 32'hff1f, 32'h0508);
    // the arbitration wait blocks data bus reads until it runs out; one cycle has passed at the read
    apb(1'b1, ssd_pkg::ARB_OFS, 32'h0);
    apb(1'b0, ssd_pkg::ARB_OFS, 32'h0);
    check(q, ssd_pkg::ARB_CYC - 1);
    dev(1'b0, ssd_pkg::DEV_CUR_DATA, 8'h00);
    check(q & 32'h6, 32'h6);
    repeat (ssd_pkg::ARB_CYC) @(posedge pclk);
    dev(1'b0, ssd_pkg::DEV_CUR_DATA, 8'h00);
    check(q & 32'h6, 32'h0);
    // a busy loss counts only while busy monitoring is on
    lose_busy <= 1'b1;
    @(posedge pclk);
    lose_busy <= 1'b0;
    dev(1'b0, 3'h5, 8'h00);
    check(q & 32'hff1f, 32'h0008);
    // with monitoring on it raises the interrupt and drops dma enable
    dev(1'b1, ssd_pkg::DEV_MODE, 8'h46);
    lose_busy <= 1'b1;
    @(posedge pclk);
    lose_busy <= 1'b0;
    dev(1'b0, 3'h5, 8'h00);
    check(q & 32'hff1f, 32'h1418);
    check({24'h0, u_dev.mode}, 32'h44);
    dev(1'b0, ssd_pkg::DEV_IRX, 8'h00);
    check(q & 32'h1f, 32'h08);
    // a command while the port is busy is refused
    apb(1'b1, ssd_pkg::CMD_OFS, 32'h0001_0500);
    dev(1'b1, ssd_pkg::DEV_SEND, 8'h00);
    check(q & 32'h1f, 32'h0a);
    // chip reset mid-run releases a raised interrupt
    lose_busy <= 1'b1;
    @(posedge pclk);
    lose_busy <= 1'b0;
    @(posedge pclk);
    check({31'h0, dev_irq}, 32'h1);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ssd_pkg::STATUS_OFS, 32'h0);
    check(q, 32'h8);
    print_verdict();
  end
endmodule
`default_nettype wire
